// ==== hw/fic_consts.svh ====
/*
  Constants of the flash programming controller: bus offsets, field
  positions, operation codes, unlock key and timing figures.
  Assumes a 125 MHz system clock and a byte-addressed 32-bit bus.
*/
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define FIC_CLK_MHZ 125
`define FIC_CYC_US(t) ((t) * `FIC_CLK_MHZ)
`define FIC_T_SHORT_US 2000
`define FIC_T_LONG_US 4000
`define FIC_UNLOCK_US 100
`define FIC_READ_CYC 32'h0000_0003

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define FIC_A_CTRL0 8'h00
`define FIC_A_CTRL2 8'h08
`define FIC_A_ADRL 8'h0C
`define FIC_A_ADRH 8'h10
`define FIC_A_DAT_LO 8'h14
`define FIC_A_DAT_HI 8'h30

// --------------------------------------------------------------
// control register fields: CTRL0 bits, and PTS in CTRL2
// --------------------------------------------------------------
`define FIC_B_UNL 3
`define FIC_B_EWT 4
`define FIC_B_EWEN 5
`define FIC_B_RDEN 6
`define FIC_B_RDT 7
`define FIC_B_CLR 8
`define FIC_B_PTS 0

// --------------------------------------------------------------
// operation codes, key, page
// --------------------------------------------------------------
`define FIC_OP_WRITE 3'h0
`define FIC_OP_ERASE 3'h1
`define FIC_OP_READ 3'h3
`define FIC_OP_UNLOCK 3'h6
`define FIC_KEY {8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40}
`define FIC_PAGE_LAST 5'h1F
`define FIC_ADRH_W 6

`endif

// ==== hw/fic_pkg.sv ====
/*
  Types shared by the flash programming controller modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fic_pkg;

  // --------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    FIC_S_IDLE = 5'h01,
    FIC_S_PROG = 5'h02,
    FIC_S_WAIT = 5'h04,
    FIC_S_READ = 5'h08,
    FIC_S_ERASE = 5'h10
  } fic_state_t;

  typedef logic [15:0] fic_word_t;

endpackage

// ==== hw/fic_ifs.sv ====
/*
  Interfaces between the controller's register file, its write
  buffer and its operation sequencer.
  Assumes all three run on one clock.
*/
interface fic_buf_if #(parameter int DEPTH = 32, parameter int W = 16);
  logic clr;
  logic ld;
  logic [$clog2(DEPTH)-1:0] ld_idx;
  logic [W-1:0] ld_data;
  logic tag_clr;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [W-1:0] rd_data;
  logic [DEPTH-1:0] tags;
  modport fill (output clr, ld, ld_idx, ld_data);
  modport store (input clr, ld, ld_idx, ld_data, tag_clr, rd_idx, output rd_data, tags);
  modport scan (output rd_idx, tag_clr, input rd_data, tags);
endinterface

interface fic_op_if;
  logic start_ew;
  logic erase;
  logic long_t;
  logic start_rd;
  logic [13:0] addr;
  logic ew_done;
  logic rd_done;
  logic [15:0] rd_word;
  modport ctl (output start_ew, erase, long_t, start_rd, addr,
               input ew_done, rd_done, rd_word);
  modport eng (input start_ew, erase, long_t, start_rd, addr,
               output ew_done, rd_done, rd_word);
endinterface

// ==== hw/fic_wbuf.sv ====
/*
  Page write buffer: one word and one tag bit per page location.
  Assumes loads and clears come from the register file, reads and
  tag clears from the sequencer.
*/
module fic_wbuf #(
  parameter int DEPTH = 32,
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fic_buf_if.store b
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] tags;
  logic [DEPTH-1:0] next_tags;

  // next buffer contents
  always_comb begin
    next_mem = mem;
    next_tags = tags;
    if (b.clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        next_mem[i] = '0;
      end
    end
    if (b.tag_clr) begin
      next_tags = '0;
    end
    if (b.ld) begin
      next_mem[b.ld_idx] = b.ld_data;
      next_tags[b.ld_idx] = 1'b1;
    end
  end

  // register the buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      tags <= '0;
    end else begin
      mem <= next_mem;
      tags <= next_tags;
    end
  end

  assign b.rd_data = mem[b.rd_idx];
  assign b.tags = tags;
endmodule

// ==== hw/fic_seq.sv ====
/*
  Operation sequencer: page erase, page program and word read
  against the flash array, with the erase/program duration timer.
  Assumes the array reads combinationally within the read window.
*/
`include "fic_consts.svh"
module fic_seq import fic_pkg::*; #(
  parameter int unsigned T_SHORT_CYC = 1,
  parameter int unsigned T_LONG_CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fic_op_if.eng op,
  fic_buf_if.scan b,
  output logic fl_erase_o,
  output logic fl_prog_o,
  output logic fl_rd_o,
  output logic [13:0] fl_addr_o,
  output logic [15:0] fl_wdata_o,
  output logic [31:0] fl_tag_o,
  input wire logic [15:0] fl_rdata_i
);
  fic_state_t st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [8:0] page, next_page;
  logic [4:0] idx, next_idx;
  logic next_erase, next_prog, next_rd, next_ewd, next_rdd;
  logic ewd, rdd;
  logic [13:0] next_addr;
  logic [15:0] next_wdata, next_word, word;
  logic [31:0] next_tag;

  // state and flash strobes
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_page = page;
    next_idx = idx;
    next_erase = 1'b0;
    next_prog = 1'b0;
    next_rd = 1'b0;
    next_ewd = 1'b0;
    next_rdd = 1'b0;
    next_addr = fl_addr_o;
    next_wdata = fl_wdata_o;
    next_tag = fl_tag_o;
    next_word = word;
    b.tag_clr = 1'b0;
    case (st)
      FIC_S_IDLE: begin
        next_page = op.addr[13:5];
        next_cnt = op.long_t ? 32'(T_LONG_CYC - 1) : 32'(T_SHORT_CYC - 1);
        if (op.start_ew && op.erase) begin
          next_st = FIC_S_ERASE;
        end else if (op.start_ew) begin
          next_idx = 5'h00;
          next_st = FIC_S_PROG;
        end else if (op.start_rd) begin
          next_rd = 1'b1;
          next_addr = op.addr;
          next_cnt = `FIC_READ_CYC - 32'h1;
          next_st = FIC_S_READ;
        end
      end
      FIC_S_ERASE: begin
        next_erase = 1'b1;
        next_addr = {page, 5'h00};
        next_tag = b.tags;
        next_st = FIC_S_WAIT;
      end
      FIC_S_PROG: begin
        next_prog = b.tags[idx];
        next_addr = {page, idx};
        next_wdata = b.rd_data;
        next_tag = b.tags;
        next_idx = idx + 5'h01;
        if (idx == `FIC_PAGE_LAST) begin
          next_st = FIC_S_WAIT;
        end
      end
      FIC_S_WAIT: begin
        next_cnt = cnt - 32'h1;
        if (cnt == 32'h0) begin
          next_ewd = 1'b1;
          b.tag_clr = 1'b1;
          next_tag = '0;
          next_st = FIC_S_IDLE;
        end
      end
      FIC_S_READ: begin
        next_rd = 1'b1;
        next_cnt = cnt - 32'h1;
        if (cnt == 32'h0) begin
          next_rd = 1'b0;
          next_word = fl_rdata_i;
          next_rdd = 1'b1;
          next_st = FIC_S_IDLE;
        end
      end
      default: begin
        next_st = FIC_S_IDLE;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= FIC_S_IDLE;
      cnt <= 32'h0;
      page <= 9'h000;
      idx <= 5'h00;
      fl_erase_o <= 1'b0;
      fl_prog_o <= 1'b0;
      fl_rd_o <= 1'b0;
      fl_addr_o <= 14'h0000;
      fl_wdata_o <= 16'h0000;
      fl_tag_o <= 32'h0000_0000;
      ewd <= 1'b0;
      rdd <= 1'b0;
      word <= 16'h0000;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      page <= next_page;
      idx <= next_idx;
      fl_erase_o <= next_erase;
      fl_prog_o <= next_prog;
      fl_rd_o <= next_rd;
      fl_addr_o <= next_addr;
      fl_wdata_o <= next_wdata;
      fl_tag_o <= next_tag;
      ewd <= next_ewd;
      rdd <= next_rdd;
      word <= next_word;
    end
  end

  assign b.rd_idx = idx;
  assign op.ew_done = ewd;
  assign op.rd_done = rdd;
  assign op.rd_word = word;
endmodule

// ==== hw/fic_iap_top.sv ====
/*
  In-application flash programming controller: register file on a
  classic Wishbone slave, unlock timer, write buffer and sequencer.
  Assumes the processor stalls on cpu_stall_o and the flash array
  answers reads combinationally on fl_rdata_i.
*/
// The Wishbone register port and the placing of the registers were decided locally.
`include "fic_consts.svh"
module fic_iap_top import fic_pkg::*; #(
  parameter int unsigned T_SHORT_CYC = `FIC_CYC_US(`FIC_T_SHORT_US),
  parameter int unsigned T_LONG_CYC = `FIC_CYC_US(`FIC_T_LONG_US),
  parameter int unsigned UNLOCK_CYC = `FIC_CYC_US(`FIC_UNLOCK_US)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cpu_stall_o,
  output logic fl_erase_o,
  output logic fl_prog_o,
  output logic fl_rd_o,
  output logic [13:0] fl_addr_o,
  output logic [15:0] fl_wdata_o,
  output logic [31:0] fl_tag_o,
  input wire logic [15:0] fl_rdata_i
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // merge the two low byte lanes of a write into an old value
  function automatic logic [15:0] lanes(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    lanes = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic [2:0] op_sel, next_op_sel;
  logic unl, next_unl;
  logic ewt, next_ewt;
  logic ewen, next_ewen;
  logic rden, next_rden;
  logic rdt, next_rdt;
  logic pts, next_pts;
  logic [13:0] adr, next_adr;
  logic [7:0] dat [8];
  logic [7:0] next_dat [8];
  logic [31:0] ucnt, next_ucnt;
  logic next_ack, next_stall;
  logic [31:0] next_rdat;

  fic_buf_if #(.DEPTH(32), .W(16)) bif ();
  fic_op_if oif ();

  logic access, wr;
  logic [2:0] didx;
  logic [15:0] c0, v;
  logic key_ok;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  // one request per ack; writes ignored while an operation runs
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i && !cpu_stall_o;
  assign didx = 3'((wb_adr_i - `FIC_A_DAT_LO) >> 2);
  assign c0 = {7'h00, 1'b0, rdt, rden, ewen, ewt, unl, op_sel};
  assign v = lanes(c0, wb_dat_i, wb_sel_i);
  // key bytes in order: low 1, high 1, low 2, high 2, low 3, high 3
  assign key_ok = ({dat[2], dat[3], dat[4], dat[5], dat[6], dat[7]}
                   == `FIC_KEY);

  // --------------------------------------------------------------
  // next register values
  // --------------------------------------------------------------
  always_comb begin
    next_op_sel = op_sel;
    next_unl = unl;
    next_ewt = ewt;
    next_ewen = ewen;
    next_rden = rden;
    next_rdt = rdt;
    next_pts = pts;
    next_adr = adr;
    next_dat = dat;
    next_ucnt = ucnt;
    bif.clr = 1'b0;
    bif.ld = 1'b0;
    bif.ld_idx = adr[4:0];
    bif.ld_data = {wb_dat_i[7:0], dat[0]};
    oif.start_ew = 1'b0;
    oif.start_rd = 1'b0;
    if (wr) begin
      if (wb_adr_i == `FIC_A_CTRL0) begin
        next_op_sel = v[2:0];
        next_rden = v[`FIC_B_RDEN];
        next_ewen = ewen && v[`FIC_B_EWEN]; // only software clear
        bif.clr = v[`FIC_B_CLR];
        if (v[`FIC_B_UNL] && v[2:0] == `FIC_OP_UNLOCK && !unl) begin
          next_unl = 1'b1;
          next_ucnt = 32'h0;
        end
        if (v[`FIC_B_EWT] && ewen &&
            (v[2:0] == `FIC_OP_WRITE || v[2:0] == `FIC_OP_ERASE)) begin
          next_ewt = 1'b1;
          oif.start_ew = 1'b1;
        end
        if (v[`FIC_B_RDT] && v[`FIC_B_RDEN] && v[2:0] == `FIC_OP_READ) begin
          next_rdt = 1'b1;
          oif.start_rd = 1'b1;
        end
      end
      if (wb_adr_i == `FIC_A_CTRL2 && wb_sel_i[0]) begin
        next_pts = wb_dat_i[`FIC_B_PTS];
      end
      if (wb_adr_i == `FIC_A_ADRL && wb_sel_i[0]) begin
        next_adr[7:0] = wb_dat_i[7:0];
      end
      if (wb_adr_i == `FIC_A_ADRH && wb_sel_i[0]) begin
        next_adr[13:8] = wb_dat_i[`FIC_ADRH_W-1:0];
      end
      if (wb_adr_i >= `FIC_A_DAT_LO && wb_adr_i <= `FIC_A_DAT_HI &&
          wb_adr_i[1:0] == 2'b00 && wb_sel_i[0]) begin
        next_dat[didx] = wb_dat_i[7:0];
        if (didx == 3'h1 &&
            (op_sel == `FIC_OP_WRITE || op_sel == `FIC_OP_ERASE)) begin
          bif.ld = 1'b1;
          if (adr[4:0] != `FIC_PAGE_LAST) begin
            next_adr[4:0] = adr[4:0] + 5'h01;
          end
        end
      end
    end
    // unlock window timer
    if (unl) begin
      next_ucnt = ucnt + 32'h1;
      if (ucnt == 32'(UNLOCK_CYC - 1)) begin
        next_unl = 1'b0;
        if (key_ok) begin
          next_ewen = 1'b1;
        end
      end
    end
    // completion from the sequencer
    if (oif.ew_done) begin
      next_ewt = 1'b0;
    end
    if (oif.rd_done) begin
      next_rdt = 1'b0;
      next_dat[0] = oif.rd_word[7:0];
      next_dat[1] = oif.rd_word[15:8];
    end
  end

  // sequencer controls
  assign oif.erase = (op_sel == `FIC_OP_ERASE);
  assign oif.long_t = pts;
  assign oif.addr = adr;

  // --------------------------------------------------------------
  // bus answer
  // --------------------------------------------------------------
  always_comb begin
    next_ack = access;
    next_rdat = 32'h0000_0000;
    next_stall = next_ewt || next_rdt;
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        `FIC_A_CTRL0: next_rdat = {16'h0000, c0};
        `FIC_A_CTRL2: next_rdat = {31'h0, pts};
        `FIC_A_ADRL: next_rdat = {24'h0, adr[7:0]};
        `FIC_A_ADRH: next_rdat = {26'h0, adr[13:8]};
        default: begin
          if (wb_adr_i >= `FIC_A_DAT_LO && wb_adr_i <= `FIC_A_DAT_HI &&
              wb_adr_i[1:0] == 2'b00) begin
            next_rdat = {24'h0, dat[didx]};
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_sel <= 3'h0;
      unl <= 1'b0;
      ewt <= 1'b0;
      ewen <= 1'b0;
      rden <= 1'b0;
      rdt <= 1'b0;
      pts <= 1'b0;
      adr <= 14'h0000;
      for (int i = 0; i < 8; i++) begin
        dat[i] <= 8'h00;
      end
      ucnt <= 32'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cpu_stall_o <= 1'b0;
    end else begin
      op_sel <= next_op_sel;
      unl <= next_unl;
      ewt <= next_ewt;
      ewen <= next_ewen;
      rden <= next_rden;
      rdt <= next_rdt;
      pts <= next_pts;
      adr <= next_adr;
      dat <= next_dat;
      ucnt <= next_ucnt;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
      cpu_stall_o <= next_stall;
    end
  end

  // --------------------------------------------------------------
  // write buffer and sequencer
  // --------------------------------------------------------------
  fic_wbuf #(.DEPTH(32), .W(16)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .b(bif.store)
  );

  fic_seq #(.T_SHORT_CYC(T_SHORT_CYC), .T_LONG_CYC(T_LONG_CYC)) u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .op(oif.eng),
    .b(bif.scan),
    .fl_erase_o(fl_erase_o),
    .fl_prog_o(fl_prog_o),
    .fl_rd_o(fl_rd_o),
    .fl_addr_o(fl_addr_o),
    .fl_wdata_o(fl_wdata_o),
    .fl_tag_o(fl_tag_o),
    .fl_rdata_i(fl_rdata_i)
  );
endmodule

// ==== bench/fic_iap_assertions.sv ====
/*
  Concurrent checks on the flash programming controller's top ports.
  Assumes one clock and a synchronous active-high reset.
*/
module fic_iap_assertions #(
  parameter int unsigned T_SHORT_CYC = 1,
  parameter int unsigned T_LONG_CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpu_stall_o,
  input wire logic fl_erase_o,
  input wire logic fl_prog_o,
  input wire logic fl_rd_o
);
  // --------------------------------------------------------------
  // stall length counter
  // --------------------------------------------------------------
  logic [31:0] stall_run;
  logic [31:0] next_stall_run;

  // counts cycles of one continuous halt
  always_comb begin
    next_stall_run = cpu_stall_o ? stall_run + 32'h1 : 32'h0;
  end

  // registers the halt count
  always_ff @(posedge clk_i) begin
    stall_run <= rst_i ? 32'h0 : next_stall_run;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_single_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  read_window_a: assert property ($rose(fl_rd_o) |-> fl_rd_o [*3] ##1 !fl_rd_o)
    else $error("read window not three cycles");
  read_halts_a: assert property (fl_rd_o |-> cpu_stall_o)
    else $error("array read without processor halt");
  change_halts_a: assert property (fl_erase_o || fl_prog_o |-> cpu_stall_o)
    else $error("erase or program without processor halt");
  erase_pulse_a: assert property (fl_erase_o |-> !fl_prog_o ##1 !fl_erase_o)
    else $error("erase pulse malformed");
  stall_bound_a: assert property (stall_run <= T_LONG_CYC + 48)
    else $error("halt outlasts the longest operation");
endmodule

bind fic_iap_top fic_iap_assertions #(
  .T_SHORT_CYC(T_SHORT_CYC),
  .T_LONG_CYC(T_LONG_CYC)
) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .cpu_stall_o(cpu_stall_o),
  .fl_erase_o(fl_erase_o),
  .fl_prog_o(fl_prog_o),
  .fl_rd_o(fl_rd_o)
);

// ==== bench/fic_flash_model.sv ====
/*
  Behavioural flash array: page erase by tag mask, word program that
  can only set bits, combinational word read.
  Assumes erased words read 0000h and the array starts with word = address.
*/
module fic_flash_model (
  input wire logic clk_i,
  input wire logic erase_i,
  input wire logic prog_i,
  input wire logic rd_i,
  input wire logic [13:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [31:0] tag_i,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:16383];
  logic [15:0] last = 16'h0000;

  // known starting contents
  initial for (int i = 0; i < 16384; i++) mem[i] = 16'(i);

  // tagged words of the page erased, programming only sets bits
  always @(posedge clk_i) begin
    if (erase_i) begin
      for (int i = 0; i < 32; i++) begin
        if (tag_i[i]) mem[{addr_i[13:5], 5'(i)}] <= 16'h0000;
      end
    end
    if (prog_i) mem[addr_i] <= mem[addr_i] | wdata_i;
    if (rd_i) last <= mem[addr_i];
  end

  // outside the read window the bus shows the inverse of the last word
  assign rdata_o = rd_i ? mem[addr_i] : ~last;
endmodule

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the flash programming controller.
  Assumes the flash model and the bound checker are compiled alongside.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TS = 20;
  localparam int unsigned TL = 40;
  localparam int unsigned TU = 30;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cpu_stall_o, fl_erase_o, fl_prog_o, fl_rd_o;
  logic [13:0] fl_addr_o;
  logic [15:0] fl_wdata_o, fl_rdata_i;
  logic [31:0] fl_tag_o;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int n, ns, nl;
  logic [7:0] koff [6] = '{8'h1C, 8'h24, 8'h2C, 8'h20, 8'h28, 8'h30};
  logic [7:0] kval [6] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
  logic [7:0] regs [8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h30, 8'h04, 8'hFC};
  logic [15:0] dw [3] = '{16'h1234, 16'h00FF, 16'hBEEF};

  // clock and cycle ceiling
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  fic_iap_top #(.T_SHORT_CYC(TS), .T_LONG_CYC(TL), .UNLOCK_CYC(TU)) u_dut (.*);
  fic_flash_model u_flash (.clk_i(clk_i), .erase_i(fl_erase_o), .prog_i(fl_prog_o),
    .rd_i(fl_rd_o), .addr_i(fl_addr_o), .wdata_i(fl_wdata_o), .tag_i(fl_tag_o),
    .rdata_o(fl_rdata_i));

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle, released at the edge that samples ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wait_idle(output int c);
    c = 0;
    while (cpu_stall_o === 1'b1) begin
      @(posedge clk_i);
      c++;
    end
  endtask

  task automatic op(input logic [31:0] d, output int c);
    wr(8'h00, d);
    wait_idle(c);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[i]) rd(regs[i], 32'h0);
    // trigger while locked
    op(32'h11, n);
    chk(n, 0);
    rd(8'h00, 32'h01);
    // word read without unlock
    wr(8'h0C, 32'h35);
    wr(8'h10, 32'h1A);
    op(32'hC3, n);
    chk({31'h0, n <= 3}, 32'h1);
    rd(8'h14, 32'h35);
    rd(8'h18, 32'h1A);
    rd(8'h00, 32'h43);
    // wrong key, then right key
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h0E);
      foreach (koff[i]) wr(koff[i], {24'h0, kval[i] ^ ((k == 0) ? 8'h01 : 8'h00)});
      repeat (TU) @(posedge clk_i);
      rd(8'h00, (k == 0) ? 32'h06 : 32'h26);
    end
    // tag a whole page and erase it, with a write refused meanwhile
    wr(8'h0C, 32'h40);
    wr(8'h10, 32'h00);
    wr(8'h00, 32'h21);
    repeat (33) wr(8'h18, 32'h0);
    rd(8'h0C, 32'h5F);
    wr(8'h00, 32'h31);
    wr(8'h0C, 32'h77);
    wait_idle(n);
    rd(8'h0C, 32'h5F);
    rd(8'h00, 32'h21);
    for (int i = 0; i < 32; i++) chk(u_flash.mem[14'h40 + i], 32'h0);
    chk(u_flash.mem[14'h60], 32'h60);
    // duration select
    op(32'h31, ns);
    wr(8'h08, 32'h1);
    op(32'h31, nl);
    chk(nl - ns, TL - TS);
    wr(8'h08, 32'h0);
    // three consecutive words into the erased page
    wr(8'h0C, 32'h40);
    wr(8'h00, 32'h120);
    foreach (dw[i]) begin
      wr(8'h14, {24'h0, dw[i][7:0]});
      wr(8'h18, {24'h0, dw[i][15:8]});
    end
    rd(8'h0C, 32'h43);
    op(32'h30, n);
    foreach (dw[i]) chk(u_flash.mem[14'h40 + i], dw[i]);
    chk(u_flash.mem[14'h43], 32'h0);
    // clear, reload and rewrite the first word without erase
    wr(8'h0C, 32'h40);
    wr(8'h00, 32'h120);
    wr(8'h14, 32'h34);
    wr(8'h18, 32'h5A);
    op(32'h30, n);
    chk(u_flash.mem[14'h40], 32'h5A34);
    chk(u_flash.mem[14'h41], 32'h00FF);
    // lock again and try once more
    wr(8'h00, 32'h00);
    op(32'h10, n);
    chk(n, 0);
    rd(8'h00, 32'h00);
    tally_and_finish();
  end
endmodule
